//--- adc_control.sv
// What this block does
// - New data bit on each shift-clock fall.
// - Frame is two zeros, fourteen result bits.
// - After sixteenth fall, hold, then release output.
// - Parameter picks two's complement or binary.
// - Busy rises on start fall, falls at end.
// - Start fall when idle holds sample, starts conversion.
// - Start still low at end: power down.
// - Rising start edge wakes from power down.
// - Conversion 5 us fast, 10 us sleeping.
// - Auto-sleep hold comes 5 us after rise.
`timescale 1ns/10ps
`include "adc_consts.svh"
module adc_control #(
  parameter bit BIPOLAR = 1'b1
) (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST_B,
  // Conversion control.
  input wire logic CONVERSION_START_N,
  output logic BUSY,
  output logic HOLD,
  output logic POWER_DOWN,
  // Converter core.
  input wire adc_pkg::result_t SAMPLE,
  // Serial link.
  input wire logic SHIFT_CLK,
  output logic SERIAL_RESULT_OUT,
  output logic SERIAL_RESULT_OUT_EN
);
  import adc_pkg::*;

  logic [1:0] start_sync;
  logic start_prev;
  logic [1:0] sclk_sync;
  logic sclk_prev;
  logic start_fall;
  logic start_rise;
  logic sclk_fall;
  conv_state_t state;
  logic [10:0] timer;
  logic slept;
  logic load;
  result_t result;
  serial_drive_t drive;

  // Both pins are asynchronous to MCLK.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      start_sync <= 2'h3;
      start_prev <= 1'b1;
      sclk_sync <= 2'h0;
      sclk_prev <= 1'b0;
    end else begin
      start_sync <= {start_sync[0], CONVERSION_START_N};
      start_prev <= start_sync[1];
      sclk_sync <= {sclk_sync[0], SHIFT_CLK};
      sclk_prev <= sclk_sync[1];
    end
  end

  assign start_fall = start_prev && !start_sync[1];
  assign start_rise = !start_prev && start_sync[1];
  assign sclk_fall = sclk_prev && !sclk_sync[1];

  // A woken part times the whole cycle from the rising edge, so its
  // conversion totals the longer figure when the high pulse is short.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= ST_IDLE;
      timer <= '0;
      slept <= 1'b0;
      load <= 1'b0;
    end else begin
      load <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (start_fall) begin
            state <= ST_CONV;
            timer <= 11'(`CONV_HS_CYC);
            slept <= 1'b0;
          end
        end
        ST_CONV: begin
          if (timer == 11'h001) begin
            load <= 1'b1;
            state <= start_sync[1] ? ST_IDLE : ST_SLEEP;
          end
          timer <= timer - 11'h001;
        end
        ST_SLEEP: begin
          if (start_rise) begin
            state <= ST_WAKE;
            timer <= 11'(`WAKE_CYC);
            slept <= 1'b1;
          end
        end
        ST_WAKE: begin
          if (timer == 11'h001) begin
            state <= ST_CONV;
            timer <= 11'(`CONV_AS_CYC - `WAKE_CYC);
          end else begin
            timer <= timer - 11'h001;
          end
        end
      endcase
    end
  end

  // Hold is taken on the start fall, or on wake expiry when asleep.
  // A start fall while waking only raises busy; the sample is held
  // later, when the wake-up time has run out.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      BUSY <= 1'b0;
      HOLD <= 1'b0;
      POWER_DOWN <= 1'b0;
    end else begin
      if (state == ST_IDLE && start_fall) begin
        BUSY <= 1'b1;
        HOLD <= 1'b1;
      end else if (state == ST_WAKE) begin
        if (start_fall) begin
          BUSY <= 1'b1;
        end
        if (timer == 11'h001) begin
          HOLD <= 1'b1;
        end
      end else if (state == ST_CONV && timer == 11'h001) begin
        BUSY <= 1'b0;
        HOLD <= 1'b0;
      end
      POWER_DOWN <= (state == ST_SLEEP);
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      result <= '0;
    end else if (state == ST_CONV && timer == 11'h001) begin
      result <= BIPOLAR ? SAMPLE : (SAMPLE ^ `MSB_FLIP);
    end
  end

  adc_shifter shifter (
    .clk(MCLK),
    .rst_n(RST_B),
    .load(load),
    .result(result),
    .shift_fall(sclk_fall),
    .drive(drive)
  );

  assign SERIAL_RESULT_OUT = drive.data;
  assign SERIAL_RESULT_OUT_EN = drive.enable;
endmodule

//--- adc_consts.svh
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

`define CLK_PERIOD_NS 10
`define CONV_HS_NS 5000
`define CONV_AS_NS 10000
`define WAKE_NS 5000
`define CONV_HS_CYC (`CONV_HS_NS / `CLK_PERIOD_NS)
`define CONV_AS_CYC (`CONV_AS_NS / `CLK_PERIOD_NS)
`define WAKE_CYC (`WAKE_NS / `CLK_PERIOD_NS)
`define HOLD_NS 10
`define HOLD_CYC ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RES_BITS 14
`define FRAME_BITS 16
`define FRAME_LAST 5'h0010
`define LEAD_ZEROS 2'h0
`define MSB_FLIP 14'h2000

`endif

//--- adc_pkg.sv
package adc_pkg;
  typedef logic [13:0] result_t;
  typedef struct packed {
    logic data;
    logic enable;
  } serial_drive_t;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CONV  = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_WAKE  = 4'b1000
  } conv_state_t;
endpackage

//--- adc_shifter.sv
`timescale 1ns/10ps
`include "adc_consts.svh"
module adc_shifter (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Frame control.
  input wire logic load,
  input wire adc_pkg::result_t result,
  input wire logic shift_fall,
  // Serial output drive.
  output adc_pkg::serial_drive_t drive
);
  import adc_pkg::*;

  logic [`FRAME_BITS-1:0] frame;
  logic [4:0] count;
  logic armed;
  logic active;
  logic [3:0] hold;

  // A frame only opens on a falling shift edge once a result is armed.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame <= '0;
      count <= '0;
      armed <= 1'b0;
      active <= 1'b0;
      hold <= '0;
      drive <= '0;
    end else begin
      if (load) begin
        frame <= {`LEAD_ZEROS, result};
        armed <= 1'b1;
      end else if (shift_fall && (armed || active)) begin
        drive.enable <= 1'b1;
        drive.data <= frame[`FRAME_BITS-1];
        frame <= {frame[`FRAME_BITS-2:0], 1'b0};
        count <= count + 5'h0001;
        armed <= 1'b0;
        active <= (count + 5'h0001) != `FRAME_LAST;
        if ((count + 5'h0001) == `FRAME_LAST) begin
          hold <= 4'(`HOLD_CYC);
        end
      end
      if (hold != '0) begin
        hold <= hold - 4'h1;
        if (hold == 4'h1) begin
          drive.enable <= 1'b0;
          count <= '0;
        end
      end
    end
  end
endmodule

//--- adc_assertions.sv
`timescale 1ns/10ps
module adc_checker (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST_B,
  // Control.
  input wire logic CONVERSION_START_N,
  input wire logic BUSY,
  input wire logic HOLD,
  input wire logic POWER_DOWN,
  // Link.
  input wire logic SHIFT_CLK,
  input wire logic SERIAL_RESULT_OUT,
  input wire logic SERIAL_RESULT_OUT_EN
);
  logic [9:0] hcnt;
  logic [4:0] fcnt;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // Counters stand in for spans too long to unroll.
  always_ff @(posedge MCLK) begin
    hcnt <= HOLD ? hcnt + 10'h001 : 10'h000;
    fcnt <= SERIAL_RESULT_OUT_EN ? fcnt + {4'h0, $fell(SHIFT_CLK)} : 5'h00;
  end
  sequence after_fall;
    $past(SHIFT_CLK, 4) && !$past(SHIFT_CLK, 3);
  endsequence
  busy_rise_a: assert property (
    $fell(CONVERSION_START_N) && !BUSY && !POWER_DOWN |-> ##3 BUSY && HOLD)
    else $error("busy late");
  hold_len_a: assert property ($fell(HOLD) |-> hcnt == 10'h1f4)
    else $error("hold span");
  busy_end_a: assert property ($fell(BUSY) |-> $fell(HOLD))
    else $error("busy end");
  sleep_entry_a: assert property (
    $fell(BUSY) && !$past(CONVERSION_START_N, 4) |-> ##[1:2] POWER_DOWN)
    else $error("no sleep");
  wake_hold_a: assert property (
    $rose(CONVERSION_START_N) && POWER_DOWN |-> ##[500:506] $rose(HOLD))
    else $error("wake hold");
  lead_zero_a: assert property (
    SERIAL_RESULT_OUT_EN && fcnt < 5'h02 |-> !SERIAL_RESULT_OUT)
    else $error("lead bit");
  bit_step_a: assert property (
    $changed(SERIAL_RESULT_OUT) && SERIAL_RESULT_OUT_EN |-> after_fall)
    else $error("bit step");
  frame_end_a: assert property (
    $fell(SERIAL_RESULT_OUT_EN) |-> fcnt == 5'h0f) else $error("frame end");
endmodule
bind adc_control adc_checker adc_checker_inst (.*);

//--- adc_master.sv
`timescale 1ns/10ps
module adc_master (
  // Link.
  output logic SHIFT_CLK = 1'b0,
  input wire logic SERIAL_RESULT_OUT,
  input wire logic SERIAL_RESULT_OUT_EN
);
  // A released line reads as the inverse of its last bit.
  task automatic read_frame(output logic [15:0] f);
    for (int i = 15; i >= 0; i--) begin
      SHIFT_CLK = 1'b1;
      #80 SHIFT_CLK = 1'b0;
      #32 f[i] = SERIAL_RESULT_OUT_EN ? SERIAL_RESULT_OUT :
        ~SERIAL_RESULT_OUT;
      #48;
    end
  endtask
endmodule

//--- testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam bit BIP = 1'b0;
  logic MCLK = 1'b0;
  logic RST_B = 1'b0;
  logic CONVERSION_START_N = 1'b1;
  logic [13:0] SAMPLE = 14'h0000;
  logic SHIFT_CLK, BUSY, HOLD, POWER_DOWN, SERIAL_RESULT_OUT;
  logic SERIAL_RESULT_OUT_EN;
  logic [15:0] exp_q[$];
  logic [15:0] frame;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  always #5 MCLK = ~MCLK;
  adc_control #(.BIPOLAR(BIP)) adc_control_inst (
    .MCLK(MCLK),
    .RST_B(RST_B),
    .CONVERSION_START_N(CONVERSION_START_N),
    .BUSY(BUSY),
    .HOLD(HOLD),
    .POWER_DOWN(POWER_DOWN),
    .SAMPLE(SAMPLE),
    .SHIFT_CLK(SHIFT_CLK),
    .SERIAL_RESULT_OUT(SERIAL_RESULT_OUT),
    .SERIAL_RESULT_OUT_EN(SERIAL_RESULT_OUT_EN)
  );
  adc_master adc_master_inst (
    .SHIFT_CLK(SHIFT_CLK),
    .SERIAL_RESULT_OUT(SERIAL_RESULT_OUT),
    .SERIAL_RESULT_OUT_EN(SERIAL_RESULT_OUT_EN)
  );
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Frames start 3 ns past an edge, so every bit is taken mid-window.
  task automatic read(input logic [15:0] exp);
    #3;
    adc_master_inst.read_frame(frame);
    check(frame, exp);
    check(SERIAL_RESULT_OUT_EN, 1'b0);
    @(posedge MCLK);
  endtask
  always @(posedge MCLK) begin
    if (++cycles == 9000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(41));
    repeat (4) @(posedge MCLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge MCLK);
    read(16'hffff);
    $display("Test 0 done");
    for (int i = 1; i < 5; i++) begin
      SAMPLE <= i < 3 ? 14'h1ffe + i[13:0] : 14'($urandom);
      CONVERSION_START_N <= 1'b0;
      repeat (i == 4 ? 600 : $urandom_range(8, 2)) @(posedge MCLK);
      exp_q.push_back({2'h0, SAMPLE ^ {!BIP, 13'h0000}});
      check(POWER_DOWN, i == 4);
      CONVERSION_START_N <= 1'b1;
      repeat (600) if (!HOLD) @(posedge MCLK);
      repeat (600) if (HOLD) @(posedge MCLK);
      repeat (35) @(posedge MCLK);
      read(exp_q.pop_front());
      $display("Test %0d done", i);
    end
    give_verdict();
  end
endmodule
